// ==== dcp_pkg.sv ====
package dcp_pkg;

   localparam int          COUNT_WIDTH     = 16;
   localparam int          MODE_WIDTH      = 3;
   localparam int          TIMEBASE_COUNT  = 2;
   localparam int          FLAG_DELAY      = 2;

   localparam logic [MODE_WIDTH-1:0]  MODE_OFF        = 3'h0;
   localparam logic [MODE_WIDTH-1:0]  MODE_CONTINUOUS = 3'h5;
   localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO      = 16'h0000;
   localparam logic [COUNT_WIDTH-1:0] COUNT_ONE       = 16'h0001;
   localparam logic                   SELECT_RESET    = 1'b0;
   localparam logic                   PIN_RESET       = 1'b0;
   localparam logic                   FLAG_RESET      = 1'b0;

   typedef logic [COUNT_WIDTH-1:0] count_t;

   typedef struct packed {
      logic                  timebase_select;
      logic [MODE_WIDTH-1:0] compare_mode_field;
   } compare_control_t;

   localparam compare_control_t CONTROL_RESET = '{SELECT_RESET, MODE_OFF};

   typedef struct packed {
      logic   timebase_run;
      count_t timebase_period;
   } timebase_cfg_t;

   typedef struct packed {
      count_t primary_compare_value;
      count_t secondary_compare_value;
   } compare_values_t;

endpackage : dcp_pkg

// ==== dual_compare_continuous_pulse.sv ====
`timescale 1ns/1ps
`default_nettype none

module dual_compare_continuous_pulse (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire dcp_pkg::timebase_cfg_t   timebase_cfg [dcp_pkg::TIMEBASE_COUNT],
   input  wire dcp_pkg::compare_values_t compare_values,
   input  wire logic                     control_write,
   input  wire dcp_pkg::compare_control_t control_wdata,
   input  wire logic                     compare_event_enable,
   input  wire logic                     flag_clear,
   output var  dcp_pkg::compare_control_t compare_control,
   output var  dcp_pkg::count_t          timebase_count [dcp_pkg::TIMEBASE_COUNT],
   output logic                          compare_output_pin,
   output logic                          compare_event_flag,
   output logic                          compare_event_request
);
   import dcp_pkg::*;

   // A match counts only on the cycle after the count moved onto the value,
   // so a stopped timer parked on a value cannot keep matching.
   function automatic logic arrived_at(input count_t count,
                                       input count_t value,
                                       input logic   moved);
      arrived_at = moved && (count == value);
   endfunction : arrived_at

   // Timebases
   count_t next_count [TIMEBASE_COUNT];
   logic   moved      [TIMEBASE_COUNT];
   logic   next_moved [TIMEBASE_COUNT];

   always_comb begin
      for (int i = 0; i < TIMEBASE_COUNT; i++) begin
         next_count[i] = timebase_count[i];
         next_moved[i] = 1'b0;
         if (timebase_cfg[i].timebase_run) begin
            next_moved[i] = 1'b1;
            if (timebase_count[i] == timebase_cfg[i].timebase_period) begin
               next_count[i] = COUNT_ZERO;
            end else begin
               next_count[i] = timebase_count[i] + COUNT_ONE;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < TIMEBASE_COUNT; i++) begin
            timebase_count[i] <= COUNT_ZERO;
            moved[i]          <= 1'b0;
         end
      end else begin
         for (int i = 0; i < TIMEBASE_COUNT; i++) begin
            timebase_count[i] <= next_count[i];
            moved[i]          <= next_moved[i];
         end
      end
   end

   a_wrap_second: assert property (@(posedge clk) disable iff (!rst_n)
      timebase_cfg[1].timebase_run
      && timebase_count[1] == timebase_cfg[1].timebase_period
      |=> timebase_count[1] == COUNT_ZERO)
      else $error("Second timebase did not return to zero after period");

   // A count left above a lowered period still steps; it only wraps on equality
   a_step_first: assert property (@(posedge clk) disable iff (!rst_n)
      timebase_cfg[0].timebase_run
      && timebase_count[0] != timebase_cfg[0].timebase_period
      |=> timebase_count[0] == $past(timebase_count[0]) + COUNT_ONE)
      else $error("First timebase did not step by one");

   a_step_second: assert property (@(posedge clk) disable iff (!rst_n)
      timebase_cfg[1].timebase_run
      && timebase_count[1] != timebase_cfg[1].timebase_period
      |=> timebase_count[1] == $past(timebase_count[1]) + COUNT_ONE)
      else $error("Second timebase did not step by one");

   a_hold_first: assert property (@(posedge clk) disable iff (!rst_n)
      !timebase_cfg[0].timebase_run |=> $stable(timebase_count[0]))
      else $error("First timebase moved while stopped");

   a_hold_second: assert property (@(posedge clk) disable iff (!rst_n)
      !timebase_cfg[1].timebase_run |=> $stable(timebase_count[1]))
      else $error("Second timebase moved while stopped");

   // Control register and compare source
   compare_control_t next_control;
   logic             restart;
   logic             mode_active;
   count_t           sel_count;
   count_t           sel_period;
   logic             sel_moved;
   logic             match_primary;
   logic             match_secondary;

   always_comb begin
      next_control = control_write ? control_wdata : compare_control;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         compare_control <= CONTROL_RESET;
      end else begin
         compare_control <= next_control;
      end
   end

   // Only software changes the mode, so pulses repeat with no further writes
   a_control_load: assert property (@(posedge clk) disable iff (!rst_n)
      control_write |=> compare_control == $past(control_wdata))
      else $error("Control value not loaded on write");

   a_control_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !control_write |=> $stable(compare_control))
      else $error("Control value changed without a write");

   always_comb begin
      restart     = control_write && (control_wdata.compare_mode_field == MODE_CONTINUOUS);
      mode_active = compare_control.compare_mode_field == MODE_CONTINUOUS;
      sel_count   = timebase_count[compare_control.timebase_select];
      sel_period  = timebase_cfg[compare_control.timebase_select].timebase_period;
      sel_moved   = moved[compare_control.timebase_select];
      // Secondary above period or primary above period never arrive,
      // which leaves the pin stuck as the special cases describe.
      match_primary   = arrived_at(sel_count,
                                   compare_values.primary_compare_value,
                                   sel_moved);
      match_secondary = arrived_at(sel_count,
                                   compare_values.secondary_compare_value,
                                   sel_moved);
   end

   // Pin and event pipeline
   logic                  next_pin;
   logic                  fall_event;
   logic [FLAG_DELAY-1:0] fall_pipe;
   logic [FLAG_DELAY-1:0] next_fall_pipe;
   logic                  next_flag;

   always_comb begin
      next_pin   = compare_output_pin;
      fall_event = 1'b0;
      if (restart || !mode_active) begin
         next_pin = 1'b0;
      end else if (!compare_output_pin) begin
         // Both matches together (primary equal to secondary, as in the all-zero case): no pulse at all
         if (match_primary && !match_secondary) begin
            next_pin = 1'b1;
         end
      end else if (match_secondary) begin
         next_pin   = 1'b0;
         fall_event = 1'b1;
      end
      next_fall_pipe = {fall_pipe[FLAG_DELAY-2:0], fall_event};
      // Hardware set wins over a clear in the same cycle
      next_flag = fall_pipe[FLAG_DELAY-1] ||
                  (compare_event_flag && !flag_clear);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         compare_output_pin <= PIN_RESET;
         fall_pipe          <= '0;
         compare_event_flag <= FLAG_RESET;
      end else begin
         compare_output_pin <= next_pin;
         fall_pipe          <= next_fall_pipe;
         compare_event_flag <= next_flag;
      end
   end

   assign compare_event_request = compare_event_flag && compare_event_enable;

   // Checks
   sequence s_secondary_fall;
      compare_output_pin && match_secondary && mode_active && !restart ##1 !compare_output_pin;
   endsequence

   sequence s_primary_rise;
      !compare_output_pin && match_primary && !match_secondary && mode_active && !restart;
   endsequence

   a_restart_low: assert property (@(posedge clk) disable iff (!rst_n)
      restart |=> !compare_output_pin)
      else $error("Pin not low after continuous mode write");

   a_hold_low: assert property (@(posedge clk) disable iff (!rst_n)
      !compare_output_pin && !match_primary |=> !compare_output_pin)
      else $error("Pin rose without a primary match");

   a_rise_primary: assert property (@(posedge clk) disable iff (!rst_n)
      s_primary_rise |=> compare_output_pin)
      else $error("Pin did not rise one cycle after primary match");

   a_fall_secondary: assert property (@(posedge clk) disable iff (!rst_n)
      compare_output_pin && !match_secondary && mode_active && !restart
      |=> compare_output_pin)
      else $error("Pin fell without a secondary match");

   a_flag_delay: assert property (@(posedge clk) disable iff (!rst_n)
      s_secondary_fall |-> ##2 compare_event_flag)
      else $error("Flag not set two cycles after falling edge");

   a_flag_cause: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(compare_event_flag) |-> $past(compare_output_pin, 3)
                                 && !$past(compare_output_pin, 2))
      else $error("Flag set without a preceding falling edge");

   a_counter_wrap: assert property (@(posedge clk) disable iff (!rst_n)
      timebase_cfg[0].timebase_run
      && timebase_count[0] == timebase_cfg[0].timebase_period
      |=> timebase_count[0] == COUNT_ZERO)
      else $error("Timebase did not return to zero after period");

   a_all_zero_low: assert property (@(posedge clk) disable iff (!rst_n)
      !compare_output_pin && compare_values == '0 && sel_period == COUNT_ZERO
      |=> !compare_output_pin)
      else $error("Pin rose with all compare values zero");

   a_idle_low: assert property (@(posedge clk) disable iff (!rst_n)
      !mode_active && !control_write |=> !compare_output_pin [*2])
      else $error("Pin high outside continuous mode");

   // A fall at the period end lands on count zero, where a zero primary matches
   sequence s_wrap_fall;
      s_secondary_fall ##0 (compare_values.primary_compare_value == COUNT_ZERO
                            && compare_values.secondary_compare_value == sel_period
                            && sel_period != COUNT_ZERO && sel_moved
                            && mode_active && !restart);
   endsequence

   a_one_low_cycle: assert property (@(posedge clk) disable iff (!rst_n)
      s_wrap_fall |=> compare_output_pin)
      else $error("Pin low longer than one cycle at period end");

   a_late_fall: assert property (@(posedge clk) disable iff (!rst_n)
      s_primary_rise ##0 (compare_values.primary_compare_value
                          >= compare_values.secondary_compare_value) |=> compare_output_pin)
      else $error("Pin did not rise with primary at or above secondary");

   a_wide_no_fall: assert property (@(posedge clk) disable iff (!rst_n)
      compare_output_pin && mode_active && !restart && sel_count <= sel_period
      && compare_values.secondary_compare_value > sel_period |=> compare_output_pin)
      else $error("Pin fell with secondary above period");

   a_wide_no_flag: assert property (@(posedge clk) disable iff (!rst_n)
      !compare_event_flag && fall_pipe == '0 && sel_count <= sel_period
      && compare_values.secondary_compare_value > sel_period |=> !compare_event_flag [*2])
      else $error("Flag set with secondary above period");

   a_wide_primary: assert property (@(posedge clk) disable iff (!rst_n)
      !compare_output_pin && sel_count <= sel_period
      && compare_values.primary_compare_value > sel_period |=> !compare_output_pin)
      else $error("Pin rose with primary above period");

   a_zero_no_flag: assert property (@(posedge clk) disable iff (!rst_n)
      !compare_event_flag && fall_pipe == '0 && compare_values == '0
      && sel_period == COUNT_ZERO |=> !compare_event_flag)
      else $error("Flag set with all compare values zero");

   a_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
      fall_pipe[FLAG_DELAY-1] |=> compare_event_flag)
      else $error("Flag not set at end of event pipeline");

   a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      compare_event_flag && !flag_clear |=> compare_event_flag)
      else $error("Flag dropped without a clear");

   a_clear_flag: assert property (@(posedge clk) disable iff (!rst_n)
      flag_clear && !fall_pipe[FLAG_DELAY-1] |=> !compare_event_flag)
      else $error("Flag not cleared");

   a_restart_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      restart && fall_pipe == '0 && !compare_event_flag
      |=> !compare_event_flag [*2])
      else $error("Flag set by a restart");

endmodule : dual_compare_continuous_pulse

`default_nettype wire

// ==== dual_compare_continuous_pulse_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module dual_compare_continuous_pulse_test;
   import dcp_pkg::*;
   logic             clk = 1'b0;
   logic             rst_n = 1'b0;
   timebase_cfg_t    cfg [TIMEBASE_COUNT];
   compare_values_t  vals;
   compare_control_t wdata, ctl, m_ctl;
   count_t           cnt [TIMEBASE_COUNT];
   count_t           m_cnt [TIMEBASE_COUNT];
   logic             wr, en, clr, pin, flag, req, m_pin, m_flag, d1, d2, mp, ms, m_on, m_rs;
   logic [1:0]       m_adv;
   logic [7:0]       rises;
   int               fail_count = 0;
   int               samples_checked = 0;

   always #5 clk = ~clk;

   dual_compare_continuous_pulse DUT (.clk(clk), .rst_n(rst_n), .timebase_cfg(cfg),
      .compare_values(vals), .control_write(wr), .control_wdata(wdata),
      .compare_event_enable(en), .flag_clear(clr), .compare_control(ctl),
      .timebase_count(cnt), .compare_output_pin(pin), .compare_event_flag(flag),
      .compare_event_request(req));
   pulse_load LOAD (.clk(clk), .rst_n(rst_n), .compare_output_pin(pin), .rise_count(rises));

   // Reference: a match needs the selected timebase to have advanced, so parked counts never fire
   assign mp = m_adv[m_ctl.timebase_select]
               && (m_cnt[m_ctl.timebase_select] == vals.primary_compare_value);
   assign ms = m_adv[m_ctl.timebase_select]
               && (m_cnt[m_ctl.timebase_select] == vals.secondary_compare_value);
   // A mode write lands next cycle; only a continuous-mode write restarts at once
   assign m_on = m_ctl.compare_mode_field == MODE_CONTINUOUS;
   assign m_rs = wr && (wdata.compare_mode_field == MODE_CONTINUOUS);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         m_cnt <= '{COUNT_ZERO, COUNT_ZERO};
         {m_adv, m_pin, m_flag, d1, d2} <= '0;
         m_ctl <= CONTROL_RESET;
      end else begin
         for (int i = 0; i < TIMEBASE_COUNT; i++) begin
            if (cfg[i].timebase_run) begin
               m_cnt[i] <= (m_cnt[i] == cfg[i].timebase_period) ? COUNT_ZERO
                                                                 : m_cnt[i] + COUNT_ONE;
            end
            m_adv[i] <= cfg[i].timebase_run;
         end
         if (wr) begin
            m_ctl <= wdata;
         end
         d1 <= !m_rs && m_on && m_pin && ms;
         d2 <= d1;
         m_flag <= d2 || (m_flag && !clr);
         if (m_rs || !m_on) begin
            m_pin <= 1'b0;
         end else if (!m_pin && mp && !ms) begin
            m_pin <= 1'b1;
         end else if (m_pin && ms) begin
            m_pin <= 1'b0;
         end
      end
   end

   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_bit

   task automatic check_count(input count_t got, input count_t exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_count

   // Sampled 1 ns after the falling edge so the combinational request has settled
   always @(negedge clk) begin
      #1;
      if (rst_n) begin
         check_bit(pin, m_pin);
         check_bit(flag, m_flag);
         check_bit(req, m_flag & en);
         check_count(cnt[0], m_cnt[0]);
         check_count(cnt[1], m_cnt[1]);
         check_count({12'h000, ctl}, {12'h000, m_ctl});
      end
   end

   task automatic write_mode(input logic sel, input logic [MODE_WIDTH-1:0] mode);
      wr = 1'b1;
      wdata = '{sel, mode};
      @(negedge clk);
      wr = 1'b0;
   endtask : write_mode

   // Fresh reset per case so every timebase starts from zero
   task automatic start(input count_t per0, per1, p, s, input logic sel);
      @(negedge clk) rst_n = 1'b0;
      @(negedge clk) rst_n = 1'b1;
      cfg[0] = '{1'b0, per0};
      cfg[1] = '{1'b0, per1};
      vals = '{p, s};
      @(negedge clk);
      write_mode(sel, MODE_CONTINUOUS);
      cfg[0].timebase_run = 1'b1;
      cfg[1].timebase_run = 1'b1;
   endtask : start

   task automatic run_case(input count_t per0, per1, p, s, input logic sel, input int n,
                           input logic [7:0] exp_rises);
      start(per0, per1, p, s, sel);
      repeat (n) @(negedge clk);
      check_count({8'h00, rises}, {8'h00, exp_rises});
   endtask : run_case

   task automatic clear_case;
      start(16'h0004, 16'h0009, 16'h0001, 16'h0003, 1'b0);
      repeat (8) @(negedge clk);
      // Clear held over three edges so the last one meets a hardware set
      clr = 1'b1;
      repeat (3) @(negedge clk);
      clr = 1'b0;
      en = 1'b0;
      repeat (4) @(negedge clk);
      en = 1'b1;
      check_count({8'h00, rises}, 16'h0003);
   endtask : clear_case

   task automatic slow_fall_case;
      start(16'h0004, 16'h0004, 16'h0001, 16'h0006, 1'b0);
      repeat (12) @(negedge clk);
      check_count({8'h00, rises}, 16'h0001);
      vals.secondary_compare_value = 16'h0003;
      repeat (12) @(negedge clk);
      check_count({8'h00, rises}, 16'h0003);
   endtask : slow_fall_case

   task automatic restart_case;
      start(16'h0004, 16'h0004, 16'h0001, 16'h0003, 1'b0);
      repeat (2) @(negedge clk);
      write_mode(1'b0, MODE_CONTINUOUS);
      repeat (8) @(negedge clk);
      write_mode(1'b0, MODE_OFF);
      repeat (8) @(negedge clk);
      check_count({8'h00, rises}, 16'h0003);
   endtask : restart_case

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   initial begin
      cfg[0] = '{1'b0, COUNT_ZERO};
      cfg[1] = '{1'b0, COUNT_ZERO};
      vals = '{COUNT_ZERO, COUNT_ZERO};
      {wr, clr, en} = 3'h1;
      wdata = CONTROL_RESET;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      clear_case();
      run_case(16'h0009, 16'h0004, 16'h0001, 16'h0003, 1'b1, 15, 8'h03);
      run_case(16'h0004, 16'h0004, 16'h0000, 16'h0003, 1'b0, 12, 8'h02);
      run_case(16'h0004, 16'h0004, 16'h0000, 16'h0004, 1'b0, 12, 8'h02);
      run_case(16'h0004, 16'h0004, 16'h0003, 16'h0001, 1'b0, 15, 8'h03);
      run_case(16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0, 10, 8'h00);
      run_case(16'h0004, 16'h0004, 16'h0006, 16'h0002, 1'b0, 10, 8'h00);
      slow_fall_case();
      restart_case();
      close_out();
   end

   // About 175 cycles are needed; fourteen times that means a hang
   initial begin
      #25000;
      fail_count++;
      close_out();
   end
endmodule : dual_compare_continuous_pulse_test

`default_nettype wire

// ==== pulse_load.sv ====
`timescale 1ns/1ps
`default_nettype none

// Load on the pulse pin; counting rises lets the bench see whether pulses repeat
module pulse_load (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic compare_output_pin,
   output logic [7:0] rise_count
);
   logic last;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last       <= 1'b0;
         rise_count <= 8'h00;
      end else begin
         last <= compare_output_pin;
         if (compare_output_pin && !last) begin
            rise_count <= rise_count + 8'h01;
         end
      end
   end
endmodule : pulse_load

`default_nettype wire
